// File: usbeb_cfg.svh
// constants of the endpoint bank handshake
`ifndef USBEB_CFG_SVH
`define USBEB_CFG_SVH
`define USBEB_EP_BYTES 7'h40
`define USBEB_CMD_SET_TXRDY 0
`define USBEB_CMD_CLR_TX_COMPLETE 1
`define USBEB_CMD_CLR_BK0 2
`define USBEB_CMD_CLR_BK1 3
`define USBEB_ADDR_CTRL 4'h0
`define USBEB_ADDR_CMD 4'h4
`define USBEB_ADDR_STATUS 4'h8
`define USBEB_ADDR_FIFO 4'hc
`define USBEB_CTRL_PP 0
`define USBEB_CTRL_TYPE_LO 1
`define USBEB_CTRL_TYPE_HI 2
`define USBEB_WCMD_TXRDY 0
`define USBEB_WCMD_TX_COMPLETE 1
`define USBEB_WCMD_RXREL 2
`define USBEB_RESP_OKAY 2'h0
`define USBEB_RESP_SLVERR 2'h2
`endif

// File: usbeb_device_end.sv
// device end: endpoint banks, bus handshakes and flags
// Overview of operation
// - firmware waits tx ready clear, single bank
// - loaded bytes plus tx ready go out
// - host ack sets tx complete, frees bank
// - interrupt pending while tx complete set
// - firmware clears tx complete after last packet
// - firmware sets tx ready before clearing complete
// - ping-pong gives two banks, one each
// - second bank fill accepted before ready clears
// - ready for bank 1 returns bank 0
// - in token with no ready bank naks
// - isochronous only on ping-pong endpoints
// - single bank out naks while firmware owns
// - stored bank 0 sets its full flag
// - byte count shown, bytes read in turn
// - clear after reading, then bank reusable
// - ping-pong out takes second packet bank 1
// - bank 1 packet sets its full flag
// - cleared bank accepts a further packet
// - firmware releases full banks strictly alternately
// - control transfers only on single bank
`timescale 1ns/1ps
`include "usbeb_cfg.svh"
module usbeb_device_end (
  input wire logic sys_clk,
  input wire logic rst,
  usbeb_if.dev ep,
  input wire logic tok_in,
  input wire logic tok_out,
  input wire logic out_byte_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_end,
  input wire logic host_ack,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last,
  output logic in_empty,
  output logic hs_ack,
  output logic hs_nak,
  output logic ep_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mem [0:127];
  logic [1:0] tx_rdy;
  logic [1:0] rx_full;
  logic [6:0] tx_len [0:1];
  logic [6:0] rx_len [0:1];
  logic fw_wbank;
  logic fw_rbank;
  logic bus_tbank;
  logic bus_rbank;
  logic [6:0] wptr;
  logic [6:0] rptr;
  logic [6:0] bptr;
  logic tx_comp;
  logic [7:0] rdata;
  logic rvalid;
  usbeb_pkg::usbeb_dev_state_t state;
  usbeb_pkg::usbeb_dev_state_t next_state;

  function automatic logic [6:0] bump(input logic [6:0] v);
    bump = (v == `USBEB_EP_BYTES) ? v : v + 7'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire pp = ep.ep_pingpong;
  wire cmd_set = ep.fw_cmd[`USBEB_CMD_SET_TXRDY];
  wire cmd_ctc = ep.fw_cmd[`USBEB_CMD_CLR_TX_COMPLETE];
  wire [1:0] cmd_clr = {ep.fw_cmd[`USBEB_CMD_CLR_BK1], ep.fw_cmd[`USBEB_CMD_CLR_BK0]};
  wire idle = state == usbeb_pkg::DEV_IDLE;
  wire in_go = idle && tok_in && tx_rdy[bus_tbank];
  wire in_nak = idle && tok_in && !tx_rdy[bus_tbank];
  wire out_go = idle && tok_out && !rx_full[bus_rbank];
  wire in_take = in_valid && in_ready;
  wire acked = state == usbeb_pkg::DEV_IN_WAIT && host_ack;
  wire out_take = state == usbeb_pkg::DEV_OUT_TAKE;
  wire out_wr = out_take && out_byte_valid && bptr != `USBEB_EP_BYTES;
  wire out_fin = out_take && out_end;
  wire out_rej = state == usbeb_pkg::DEV_OUT_DROP && out_end;
  wire fw_wok = ep.fw_wr && wptr != `USBEB_EP_BYTES;
  wire [6:0] cur_len = tx_len[bus_tbank];

  assign in_valid = state == usbeb_pkg::DEV_IN_SEND;
  assign in_data = mem[{bus_tbank, bptr[5:0]}];
  assign in_empty = cur_len == 7'h0;
  assign in_last = in_empty || (bptr + 7'h1 == cur_len);
  assign ep_irq = tx_comp || (|rx_full);
  assign ep.tx_packet_ready = tx_rdy[bus_tbank];
  assign ep.tx_complete = tx_comp;
  assign ep.rx_bank0_full = rx_full[0];
  assign ep.rx_bank1_full = rx_full[1];
  // an empty read bank shows no bytes, not the length of its last packet
  assign ep.rx_byte_count = rx_full[fw_rbank] ? rx_len[fw_rbank] : 7'h0;
  assign ep.fw_rdata = rdata;
  assign ep.fw_rvalid = rvalid;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    case (state)
      usbeb_pkg::DEV_IDLE:
      begin
        if (in_go)
          next_state = usbeb_pkg::DEV_IN_SEND;
        else if (out_go)
          next_state = usbeb_pkg::DEV_OUT_TAKE;
        else if (tok_out)
          next_state = usbeb_pkg::DEV_OUT_DROP;
      end
      usbeb_pkg::DEV_IN_SEND:
      begin
        if (in_take && in_last)
          next_state = usbeb_pkg::DEV_IN_WAIT;
      end
      usbeb_pkg::DEV_IN_WAIT:
      begin
        // lost ack: host retries with a new token, same bank resent
        if (host_ack || tok_in || tok_out)
          next_state = usbeb_pkg::DEV_IDLE;
      end
      usbeb_pkg::DEV_OUT_TAKE:
      begin
        if (out_end)
          next_state = usbeb_pkg::DEV_IDLE;
      end
      usbeb_pkg::DEV_OUT_DROP:
      begin
        if (out_end)
          next_state = usbeb_pkg::DEV_IDLE;
      end
      default:
        next_state = usbeb_pkg::DEV_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage carries no reset: contents are only meaningful behind a flag
  always_ff @(posedge sys_clk)
  begin
    if (fw_wok)
      mem[{fw_wbank, wptr[5:0]}] <= ep.fw_wdata;
    if (out_wr)
      mem[{bus_rbank, bptr[5:0]}] <= out_byte;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= usbeb_pkg::DEV_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || idle)
      bptr <= 7'h0;
    else if (in_take || out_wr)
      bptr <= bump(bptr);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
    end
    else
    begin
      hs_ack <= out_fin;
      hs_nak <= in_nak || out_rej;
    end
  end

  // transmit side: with ping-pong, firmware fills one bank while the bus owns the other
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tx_rdy <= 2'h0;
      tx_comp <= 1'b0;
      fw_wbank <= 1'b0;
      bus_tbank <= 1'b0;
      wptr <= 7'h0;
      tx_len[0] <= 7'h0;
      tx_len[1] <= 7'h0;
    end
    else
    begin
      if (acked)
      begin
        tx_rdy[bus_tbank] <= 1'b0;
        bus_tbank <= pp && !bus_tbank;
      end
      if (cmd_ctc)
        tx_comp <= 1'b0;
      if (acked)
        tx_comp <= 1'b1;
      if (cmd_set)
      begin
        tx_rdy[fw_wbank] <= 1'b1;
        tx_len[fw_wbank] <= wptr;
        fw_wbank <= pp && !fw_wbank;
        wptr <= 7'h0;
      end
      else if (fw_wok)
        wptr <= wptr + 7'h1;
    end
  end

  // receive side: banks taken and released in alternating order
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_full <= 2'h0;
      fw_rbank <= 1'b0;
      bus_rbank <= 1'b0;
      rptr <= 7'h0;
      rdata <= 8'h0;
      rvalid <= 1'b0;
      rx_len[0] <= 7'h0;
      rx_len[1] <= 7'h0;
    end
    else
    begin
      rvalid <= ep.fw_rd;
      if (ep.fw_rd)
      begin
        rdata <= mem[{fw_rbank, rptr[5:0]}];
        rptr <= bump(rptr);
      end
      if (cmd_clr[0])
        rx_full[0] <= 1'b0;
      if (cmd_clr[1])
        rx_full[1] <= 1'b0;
      if (|cmd_clr)
        rptr <= 7'h0;
      // an empty bank released keeps the read turn, as the firmware end does
      if (|(cmd_clr & rx_full))
        fw_rbank <= pp && cmd_clr[0];
      if (out_fin)
      begin
        rx_full[bus_rbank] <= 1'b1;
        rx_len[bus_rbank] <= bptr;
        bus_rbank <= pp && !bus_rbank;
      end
    end
  end
endmodule

// File: usbeb_endpoint_bank_handshake_tb_top.sv
// testbench joining firmware end and device end
`timescale 1ns/1ps
module usbeb_endpoint_bank_handshake_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tok_in = 1'b0;
  logic tok_out = 1'b0;
  logic ob_v = 1'b0;
  logic out_end = 1'b0;
  logic host_ack = 1'b0;
  logic [7:0] ob = 8'h00;
  // held ready: the bus side never stalls an in packet
  logic in_ready = 1'b1;
  logic in_valid, in_last, in_empty, hs_ack, hs_nak, ep_irq;
  logic [7:0] in_data;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  usbeb_if ep_if ();
  usbeb_device_end u_usbeb_device_end (.sys_clk(sys_clk), .rst(rst), .ep(ep_if),
    .tok_in(tok_in), .tok_out(tok_out), .out_byte_valid(ob_v), .out_byte(ob),
    .out_end(out_end), .host_ack(host_ack), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_empty(in_empty), .hs_ack(hs_ack),
    .hs_nak(hs_nak), .ep_irq(ep_irq));
  usbeb_fw_end u_usbeb_fw_end (.sys_clk(sys_clk), .rst(rst), .ep(ep_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  usbeb_props chk (.sys_clk(sys_clk), .rst(rst), .ep_pingpong(ep_if.ep_pingpong),
    .fw_wr(ep_if.fw_wr), .fw_cmd(ep_if.fw_cmd), .fw_rd(ep_if.fw_rd),
    .fw_rvalid(ep_if.fw_rvalid), .tx_packet_ready(ep_if.tx_packet_ready),
    .tx_complete(ep_if.tx_complete), .rx_bank0_full(ep_if.rx_bank0_full),
    .rx_bank1_full(ep_if.rx_bank1_full), .rx_byte_count(ep_if.rx_byte_count));
  ////////////////////////////////////////////////////////////////////////////////
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp(bresp, er);
  endtask
  task axi_rd(input logic [3:0] a, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    cmp(rresp, er);
  endtask
  // rx_turn masked: it only reflects firmware-side bookkeeping
  task st(input logic [31:0] e);
    axi_rd(4'h8, 2'h0);
    cmp(d & 32'h7f1f, e);
  endtask
  task fill(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
      axi_wr(4'hc, {24'h0, b + i[7:0]}, 2'h0);
  endtask
  task drain(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
    begin
      axi_rd(4'hc, 2'h0);
      cmp(d, {24'h0, b + i[7:0]});
    end
  endtask
  task wait_hs(input logic e);
    do @(negedge sys_clk); while (hs_ack !== 1'b1 && hs_nak !== 1'b1);
    cmp(hs_ack, e);
    cmp(hs_nak, !e);
  endtask
  task out_pkt(input int n, input logic [7:0] b, input logic e);
    @(posedge sys_clk);
    tok_out <= 1'b1;
    @(posedge sys_clk);
    tok_out <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      ob_v <= 1'b1;
      ob <= b + i[7:0];
      @(posedge sys_clk);
    end
    ob_v <= 1'b0;
    out_end <= 1'b1;
    @(posedge sys_clk);
    out_end <= 1'b0;
    wait_hs(e);
  endtask
  task in_pkt(input int n, input logic [7:0] b, input logic nak);
    @(posedge sys_clk);
    tok_in <= 1'b1;
    @(posedge sys_clk);
    tok_in <= 1'b0;
    if (nak)
      wait_hs(1'b0);
    // an empty packet still takes one beat, flagged by in_empty
    for (int i = 0; !nak && (i < n || i == 0); i++)
    begin
      do @(negedge sys_clk); while (in_valid !== 1'b1);
      if (n > 0)
        cmp(in_data, b + i[7:0]);
      cmp(in_last, i >= n - 1);
      cmp(in_empty, n == 0);
      @(posedge sys_clk);
    end
    host_ack <= !nak;
    @(posedge sys_clk);
    host_ack <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_refuse;
    axi_wr(4'h0, 32'h2, 2'h2);
    axi_wr(4'h0, 32'h1, 2'h2);
    axi_rd(4'h2, 2'h2);
    cmp(d, 32'h0);
  endtask
  task t_single_in;
    axi_wr(4'h0, 32'h4, 2'h0);
    in_pkt(0, 8'h0, 1'b1);
    fill(3, 8'h10);
    axi_wr(4'h4, 32'h1, 2'h0);
    st(32'h01);
    axi_wr(4'hc, 32'hee, 2'h2);
    in_pkt(3, 8'h10, 1'b0);
    st(32'h12);
    cmp(ep_irq, 1'b1);
    axi_wr(4'h4, 32'h3, 2'h0);
    in_pkt(0, 8'h0, 1'b0);
    st(32'h12);
    axi_wr(4'h4, 32'h2, 2'h0);
    st(32'h00);
  endtask
  task t_single_out;
    out_pkt(4, 8'h20, 1'b1);
    st(32'h0414);
    out_pkt(2, 8'h30, 1'b0);
    drain(4, 8'h20);
    axi_wr(4'h4, 32'h4, 2'h0);
    st(32'h00);
    out_pkt(1, 8'h40, 1'b1);
    axi_wr(4'h4, 32'h4, 2'h0);
  endtask
  task t_pp_out;
    axi_wr(4'h0, 32'h5, 2'h0);
    out_pkt(2, 8'h50, 1'b1);
    out_pkt(3, 8'h60, 1'b1);
    st(32'h021c);
    drain(2, 8'h50);
    axi_wr(4'h4, 32'h4, 2'h0);
    st(32'h0318);
    out_pkt(1, 8'h70, 1'b1);
    drain(3, 8'h60);
    axi_wr(4'h4, 32'h4, 2'h0);
    st(32'h0114);
    drain(1, 8'h70);
    axi_wr(4'h4, 32'h4, 2'h0);
    st(32'h00);
  endtask
  task t_pp_in;
    fill(2, 8'h80);
    axi_wr(4'h4, 32'h1, 2'h0);
    fill(2, 8'h90);
    st(32'h01);
    in_pkt(2, 8'h80, 1'b0);
    st(32'h12);
    axi_wr(4'h4, 32'h3, 2'h0);
    st(32'h01);
    in_pkt(2, 8'h90, 1'b0);
    st(32'h12);
    axi_wr(4'h4, 32'h2, 2'h0);
    st(32'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always #20 sys_clk = ~sys_clk;
  // a few hundred cycles expected; ceiling leaves wide margin
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_refuse;
    t_single_in;
    t_single_out;
    t_pp_out;
    t_pp_in;
    end_of_test;
  end
endmodule

// File: usbeb_fw_end.sv
// firmware end: axi4-lite registers driving the endpoint port
`timescale 1ns/1ps
`include "usbeb_cfg.svh"
module usbeb_fw_end (
  input wire logic sys_clk,
  input wire logic rst,
  usbeb_if.fw ep,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic ctrl_pp;
  logic [1:0] ctrl_type;
  logic rx_turn;
  logic pend_ctc;
  logic fw_wr;
  logic [7:0] fw_wdata;
  logic [3:0] fw_cmd;
  logic fw_rd;
  logic rd_wait;

  function automatic logic legal_cfg(input logic [1:0] t, input logic p);
    legal_cfg = !(t == usbeb_pkg::EP_ISO && !p) && !(t == usbeb_pkg::EP_CONTROL && p);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire exec = aw_held && w_held && !s_axi_bvalid && !pend_ctc;
  wire a_ctrl = aw_addr == `USBEB_ADDR_CTRL;
  wire a_cmd = aw_addr == `USBEB_ADDR_CMD;
  wire a_fifo = aw_addr == `USBEB_ADDR_FIFO;
  wire a_stat = aw_addr == `USBEB_ADDR_STATUS;
  wire [1:0] new_type = w_data[`USBEB_CTRL_TYPE_HI:`USBEB_CTRL_TYPE_LO];
  wire cfg_ok = legal_cfg(new_type, w_data[`USBEB_CTRL_PP]);
  wire fifo_ok = ctrl_pp || !ep.tx_packet_ready;
  wire w_err = (a_ctrl && !cfg_ok) || (a_fifo && !fifo_ok) ||
               !(a_ctrl || a_cmd || a_fifo || a_stat);
  wire do_set = exec && a_cmd && w_data[`USBEB_WCMD_TXRDY];
  wire do_ctc = exec && a_cmd && w_data[`USBEB_WCMD_TX_COMPLETE];
  wire do_rel = exec && a_cmd && w_data[`USBEB_WCMD_RXREL];
  wire turn_full = rx_turn ? ep.rx_bank1_full : ep.rx_bank0_full;
  wire irq = ep.tx_complete || ep.rx_bank0_full || ep.rx_bank1_full;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire ar_fifo = s_axi_araddr == `USBEB_ADDR_FIFO;
  wire [31:0] status = {17'h0, ep.rx_byte_count, 2'h0, rx_turn, irq, ep.rx_bank1_full,
                        ep.rx_bank0_full, ep.tx_complete, ep.tx_packet_ready};
  wire [31:0] rd_mux = (s_axi_araddr == `USBEB_ADDR_CTRL) ? {29'h0, ctrl_type, ctrl_pp} :
                       (s_axi_araddr == `USBEB_ADDR_STATUS) ? status : 32'h0;
  wire rd_bad = !(s_axi_araddr == `USBEB_ADDR_CTRL || s_axi_araddr == `USBEB_ADDR_STATUS ||
                  s_axi_araddr == `USBEB_ADDR_CMD);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !rd_wait && !s_axi_rvalid;
  assign ep.ep_pingpong = ctrl_pp;
  assign ep.fw_wr = fw_wr;
  assign ep.fw_wdata = fw_wdata;
  assign ep.fw_cmd = fw_cmd;
  assign ep.fw_rd = fw_rd;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // writes execute once both channels are held; response follows
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USBEB_RESP_OKAY;
      ctrl_pp <= 1'b0;
      ctrl_type <= usbeb_pkg::EP_CONTROL;
      rx_turn <= 1'b0;
      pend_ctc <= 1'b0;
      fw_wr <= 1'b0;
      fw_wdata <= 8'h0;
      fw_cmd <= 4'h0;
    end
    else
    begin
      fw_wr <= exec && a_fifo && fifo_ok && w_lane0;
      fw_cmd <= 4'h0;
      pend_ctc <= 1'b0;
      if (exec && a_fifo)
        fw_wdata <= w_data[7:0];
      if (exec && a_ctrl && cfg_ok && w_lane0)
      begin
        ctrl_pp <= w_data[`USBEB_CTRL_PP];
        ctrl_type <= new_type;
        rx_turn <= 1'b0;
      end
      if (do_set)
        fw_cmd[`USBEB_CMD_SET_TXRDY] <= 1'b1;
      // clearing complete waits one cycle behind the ready, never ahead
      if (do_ctc && do_set)
        pend_ctc <= 1'b1;
      else if (do_ctc)
        fw_cmd[`USBEB_CMD_CLR_TX_COMPLETE] <= 1'b1;
      if (pend_ctc)
        fw_cmd[`USBEB_CMD_CLR_TX_COMPLETE] <= 1'b1;
      if (do_rel)
      begin
        fw_cmd[{1'b1, rx_turn}] <= 1'b1;
        if (turn_full)
          rx_turn <= ctrl_pp && !rx_turn;
      end
      if ((exec && !do_ctc) || (exec && !do_set) || pend_ctc)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_err ? `USBEB_RESP_SLVERR : `USBEB_RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // fifo reads pull one byte from the device, one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `USBEB_RESP_OKAY;
      fw_rd <= 1'b0;
      rd_wait <= 1'b0;
    end
    else
    begin
      fw_rd <= ar_take && ar_fifo;
      if (ar_take && ar_fifo)
        rd_wait <= 1'b1;
      else if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_bad ? `USBEB_RESP_SLVERR : `USBEB_RESP_OKAY;
      end
      else if (rd_wait && ep.fw_rvalid)
      begin
        rd_wait <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, ep.fw_rdata};
        s_axi_rresp <= `USBEB_RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: usbeb_if.sv
// endpoint port between firmware side and device side
`timescale 1ns/1ps
interface usbeb_if;
  logic ep_pingpong;
  logic fw_wr;
  logic [7:0] fw_wdata;
  logic [3:0] fw_cmd;
  logic fw_rd;
  logic [7:0] fw_rdata;
  logic fw_rvalid;
  logic tx_packet_ready;
  logic tx_complete;
  logic rx_bank0_full;
  logic rx_bank1_full;
  logic [6:0] rx_byte_count;
  modport dev (
    input ep_pingpong, fw_wr, fw_wdata, fw_cmd, fw_rd,
    output fw_rdata, fw_rvalid, tx_packet_ready, tx_complete,
    output rx_bank0_full, rx_bank1_full, rx_byte_count
  );
  modport fw (
    output ep_pingpong, fw_wr, fw_wdata, fw_cmd, fw_rd,
    input fw_rdata, fw_rvalid, tx_packet_ready, tx_complete,
    input rx_bank0_full, rx_bank1_full, rx_byte_count
  );
endinterface

// File: usbeb_pkg.sv
// types of the endpoint bank handshake
package usbeb_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_IN_SEND = 3'h1,
    DEV_IN_WAIT = 3'h2,
    DEV_OUT_TAKE = 3'h3,
    DEV_OUT_DROP = 3'h4
  } usbeb_dev_state_t;
  typedef enum logic [1:0] {
    EP_CONTROL = 2'h0,
    EP_ISO = 2'h1,
    EP_BULK = 2'h2,
    EP_INTR = 2'h3
  } usbeb_ep_type_t;
endpackage

// File: usbeb_props.sv
// assertions on the endpoint port between the two ends
`timescale 1ns/1ps
module usbeb_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ep_pingpong,
  input wire logic fw_wr,
  input wire logic [3:0] fw_cmd,
  input wire logic fw_rd,
  input wire logic fw_rvalid,
  input wire logic tx_packet_ready,
  input wire logic tx_complete,
  input wire logic rx_bank0_full,
  input wire logic rx_bank1_full,
  input wire logic [6:0] rx_byte_count
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (fw_rd |=> fw_rvalid)
    else $error("fifo byte not returned");
  rvalid_cause_a: assert property (fw_rvalid |-> $past(fw_rd))
    else $error("fifo byte without read");
  count_max_a: assert property (rx_byte_count <= 7'h40)
    else $error("byte count above bank size");
  txrdy_set_a: assert property (fw_cmd[0] && !ep_pingpong |=> tx_packet_ready)
    else $error("tx ready not set");
  fill_refuse_a: assert property (!ep_pingpong && tx_packet_ready |-> !fw_wr)
    else $error("fill while single bank ready");
  cmd_order_a: assert property (fw_cmd[0] |-> !fw_cmd[1])
    else $error("clear issued with set");
  tx_complete_hold_a: assert property (tx_complete && !fw_cmd[1] |=> tx_complete)
    else $error("tx complete dropped");
  bk0_hold_a: assert property (rx_bank0_full && !fw_cmd[2] |=> rx_bank0_full)
    else $error("bank 0 flag dropped");
  bk1_hold_a: assert property (rx_bank1_full && !fw_cmd[3] |=> rx_bank1_full)
    else $error("bank 1 flag dropped");
  bk0_release_a: assert property (fw_cmd[2] |=> !rx_bank0_full)
    else $error("bank 0 not released");
  single_bank_a: assert property (!ep_pingpong |-> !rx_bank1_full)
    else $error("bank 1 used on single bank");
endmodule
